/* core/afpd_defines.svh */
// Frame codes, field positions and reset values of the frame program decoder
`ifndef AFPD_DEFINES_SVH
`define AFPD_DEFINES_SVH

// ==========================================
// Frame layout
`define AFPD_FRAME_BITS 16
`define AFPD_CNT_LAST 5'h0F
`define AFPD_TOP_HI 15
`define AFPD_TOP_LO 12
`define AFPD_DEPTH_HI 9
`define AFPD_DEPTH_LO 6
`define AFPD_CLOW_HI 15
`define AFPD_CLOW_LO 14
`define AFPD_HILO_BIT 13
`define AFPD_EXIT_BIT 12
`define AFPD_THR_HI 9
`define AFPD_THR_LO 0
`define AFPD_PROG_EN_BIT 11
`define AFPD_RANGE_BIT 6
`define AFPD_GPO_HI 3
`define AFPD_GPO_LO 0

// ==========================================
// Command codes in the top nibble
`define AFPD_CODE_KEEP 4'h0
`define AFPD_CODE_MANUAL 4'h1
`define AFPD_CODE_SCAN_LIST 4'h2
`define AFPD_CODE_SCAN_DEPTH 4'h3
`define AFPD_CODE_DEPTH_PROG 4'h9
`define AFPD_ALARM_PREFIX 2'h3

// ==========================================
// Reset values
`define AFPD_RST_LAST_CH 4'hF
`define AFPD_RST_THR_HI 10'h3FF
`define AFPD_RST_THR_LO 10'h000
`define AFPD_RST_RANGE 1'b0
`define AFPD_RST_GPO 4'h0

`endif

/* core/afpd_pkg.sv */
// Types of the frame program decoder
package afpd_pkg;
	// Decoder state, Gray coded
	typedef enum logic [1:0] {
		AFPD_ST_NORMAL = 2'b00,
		AFPD_ST_ALARM = 2'b01
	} afpd_state_t;

	// Channel sequencing mode supplied by the core
	typedef enum logic [1:0] {
		AFPD_MODE_MANUAL = 2'b00,
		AFPD_MODE_LIST = 2'b01,
		AFPD_MODE_DEPTH = 2'b11
	} afpd_mode_t;
endpackage

/* core/afpd_decoder.sv */
// Serial frame program decoder: depth scan, keep-mode and alarm threshold frames
// Operation
// - Code 1001 loads the depth-scan register
// - Bits 9..6 give the last channel
// - Depth scan counts up from channel zero
// - After last channel, wrap to zero
// - Code 0000 keeps mode, counter advances normally
// - Code 0000 ignores low twelve bits
// - Each channel has high and low threshold
// - Thresholds grouped by four channels per group
// - Group n covers channels 4n to 4n+3
// - Code 11bb starts programming for group bb
// - Nine frames program a full group
// - Exit flag leaves sequence after that frame
// - Conversion data keeps flowing while programming
// - No range or output change while programming
// - Depth program completes in one frame
// - Bits 15..12: channel bits, high/low, exit
// - Ten-bit threshold compared with upper result
// - Without exit, all frames are thresholds
`timescale 1ns/1ps
`default_nettype none
`include "afpd_defines.svh"

module afpd_decoder #(
	parameter int CHANNELS = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	input wire logic [1:0] mode_sel,
	input wire logic [3:0] manual_channel,
	input wire logic [11:0] conv_result,
	output logic [3:0] channel,
	output logic [3:0] last_channel_code,
	output logic range_sel,
	output logic [3:0] gpo_data,
	output logic prog_active,
	output logic alarm_high,
	output logic alarm_low
);
	localparam int GROUPS = CHANNELS / 4;

	// Elaboration check on channel count
	if (CHANNELS != 4 && CHANNELS != 8 && CHANNELS != 12 && CHANNELS != 16)
	begin : g_bad_channels
		$error("CHANNELS must be 4, 8, 12 or 16");
	end

	// ==========================================
	// Link domain: frame shifter on sclk
	logic [4:0] bit_cnt_ff;
	logic [15:0] shift_ff;
	logic [15:0] sdo_shift_ff;
	logic [15:0] frame_word_ff;
	logic frame_tgl_ff;
	logic [15:0] sdo_word_ff;
	wire link_rst = rst | cs_n;
	wire [15:0] shift_in = {shift_ff[14:0], sdi};
	wire frame_last = (bit_cnt_ff == `AFPD_CNT_LAST);

	// Bit counter and shifters, cleared while chip select is high
	always_ff @(posedge sclk or posedge link_rst)
	begin
		if (link_rst)
		begin
			bit_cnt_ff <= 5'h00;
			shift_ff <= 16'h0000;
			sdo_shift_ff <= 16'h0000;
		end
		else
		begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
			shift_ff <= shift_in;
			sdo_shift_ff <= (bit_cnt_ff == 5'h00) ? {sdo_word_ff[14:0], 1'b0}
				: {sdo_shift_ff[14:0], 1'b0};
		end
	end

	// Completed frame word and its event toggle
	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
		begin
			frame_word_ff <= 16'h0000;
			frame_tgl_ff <= 1'b0;
		end
		else if (frame_last)
		begin
			frame_word_ff <= shift_in;
			frame_tgl_ff <= ~frame_tgl_ff;
		end
	end

	// Bit 15 leaves before the first edge, later bits from the shifter
	assign sdo = (bit_cnt_ff == 5'h00) ? sdo_word_ff[15] : sdo_shift_ff[15];

	// ==========================================
	// Crossing: frame toggle into the clk domain
	logic tgl_s1_ff;
	logic tgl_s2_ff;
	logic tgl_s3_ff;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tgl_s1_ff <= 1'b0;
			tgl_s2_ff <= 1'b0;
			tgl_s3_ff <= 1'b0;
		end
		else
		begin
			tgl_s1_ff <= frame_tgl_ff;
			tgl_s2_ff <= tgl_s1_ff;
			tgl_s3_ff <= tgl_s2_ff;
		end
	end
	wire frame_evt = tgl_s2_ff ^ tgl_s3_ff;
	// Word held stable for a whole frame after the toggle
	wire [15:0] word = frame_word_ff;

	// ==========================================
	// Command decode
	afpd_pkg::afpd_state_t state_ff;
	afpd_pkg::afpd_state_t nxt_state;
	logic [3:0] ch_ff;
	logic [3:0] nxt_ch;
	logic [3:0] last_ch_ff;
	logic [1:0] group_ff;
	logic range_ff;
	logic [3:0] gpo_ff;
	logic alarm_high_ff;
	logic alarm_low_ff;
	logic [9:0] thr_hi_ff [CHANNELS];
	logic [9:0] thr_lo_ff [CHANNELS];

	wire [3:0] top = word[`AFPD_TOP_HI:`AFPD_TOP_LO];
	wire in_alarm = (state_ff == afpd_pkg::AFPD_ST_ALARM);
	wire in_normal = (state_ff == afpd_pkg::AFPD_ST_NORMAL);
	wire [1:0] req_group = top[1:0];
	wire group_ok = ({30'h0, req_group} < GROUPS);
	wire is_depth_prog = in_normal && (top == `AFPD_CODE_DEPTH_PROG);
	wire is_alarm_req = in_normal && (top[3:2] == `AFPD_ALARM_PREFIX) && group_ok;
	wire is_mode_frame = in_normal && (top == `AFPD_CODE_MANUAL || top == `AFPD_CODE_SCAN_LIST
		|| top == `AFPD_CODE_SCAN_DEPTH);
	wire thr_write = frame_evt && in_alarm;
	wire [3:0] thr_idx = {group_ff, word[`AFPD_CLOW_HI:`AFPD_CLOW_LO]};
	wire thr_is_hi = word[`AFPD_HILO_BIT];
	wire thr_exit = word[`AFPD_EXIT_BIT];
	wire [9:0] thr_val = word[`AFPD_THR_HI:`AFPD_THR_LO];
	wire ch_at_last = (ch_ff == last_ch_ff);
	wire ch_at_top = (ch_ff == 4'(CHANNELS - 1));

	// Next state of the programming sequence
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			afpd_pkg::AFPD_ST_NORMAL:
			begin
				if (frame_evt && is_alarm_req)
					nxt_state = afpd_pkg::AFPD_ST_ALARM;
			end
			afpd_pkg::AFPD_ST_ALARM:
			begin
				if (frame_evt && thr_exit)
					nxt_state = afpd_pkg::AFPD_ST_NORMAL;
			end
			default: nxt_state = afpd_pkg::AFPD_ST_NORMAL;
		endcase
	end

	// Per-frame channel advance, independent of programming
	always_comb
	begin
		nxt_ch = ch_ff;
		case (mode_sel)
			afpd_pkg::AFPD_MODE_MANUAL: nxt_ch = manual_channel;
			afpd_pkg::AFPD_MODE_DEPTH: nxt_ch = ch_at_last ? 4'h0 : ch_ff + 4'h1;
			afpd_pkg::AFPD_MODE_LIST: nxt_ch = ch_at_top ? 4'h0 : ch_ff + 4'h1;
			default: nxt_ch = ch_ff;
		endcase
	end

	// State, channel and group registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= afpd_pkg::AFPD_ST_NORMAL;
			ch_ff <= 4'h0;
			group_ff <= 2'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (frame_evt)
				ch_ff <= nxt_ch;
			if (frame_evt && is_alarm_req)
				group_ff <= req_group;
		end
	end

	// Depth-scan program register, one frame
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			last_ch_ff <= `AFPD_RST_LAST_CH;
		else if (frame_evt && is_depth_prog)
			last_ch_ff <= word[`AFPD_DEPTH_HI:`AFPD_DEPTH_LO];
	end

	// Range and output data only from mode frames outside programming
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			range_ff <= `AFPD_RST_RANGE;
			gpo_ff <= `AFPD_RST_GPO;
		end
		else if (frame_evt && is_mode_frame)
		begin
			if (word[`AFPD_PROG_EN_BIT])
				range_ff <= word[`AFPD_RANGE_BIT];
			gpo_ff <= word[`AFPD_GPO_HI:`AFPD_GPO_LO];
		end
	end

	// Threshold registers, one high and one low per channel
	for (genvar i = 0; i < CHANNELS; i++)
	begin : g_thr
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
			begin
				thr_hi_ff[i] <= `AFPD_RST_THR_HI;
				thr_lo_ff[i] <= `AFPD_RST_THR_LO;
			end
			else if (thr_write && thr_idx == 4'(i))
			begin
				if (thr_is_hi)
					thr_hi_ff[i] <= thr_val;
				else
					thr_lo_ff[i] <= thr_val;
			end
		end
	end

	// Alarm compare on the upper ten result bits
	wire [9:0] res_top = conv_result[11:2];
	wire ch_ok = ({28'h0, ch_ff} < CHANNELS);
	wire [3:0] cmp_idx = ch_ok ? ch_ff : 4'h0;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			alarm_high_ff <= 1'b0;
			alarm_low_ff <= 1'b0;
		end
		else
		begin
			alarm_high_ff <= ch_ok && (res_top > thr_hi_ff[cmp_idx]);
			alarm_low_ff <= ch_ok && (res_top < thr_lo_ff[cmp_idx]);
		end
	end

	// Serial-out word: channel and result, updated per frame
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sdo_word_ff <= 16'h0000;
		else if (frame_evt)
			sdo_word_ff <= {nxt_ch, conv_result};
	end

	assign channel = ch_ff;
	assign last_channel_code = last_ch_ff;
	assign range_sel = range_ff;
	assign gpo_data = gpo_ff;
	assign prog_active = in_alarm;
	assign alarm_high = alarm_high_ff;
	assign alarm_low = alarm_low_ff;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_DEPTH_LOAD: assert property (frame_evt && is_depth_prog
		|=> last_ch_ff == $past(word[9:6]))
		else $error("depth register not loaded");
	AST_ADVANCE: assert property (frame_evt && mode_sel == 2'b11 && !ch_at_last
		|=> ch_ff == $past(ch_ff) + 4'h1)
		else $error("depth scan did not advance");
	AST_WRAP: assert property (frame_evt && mode_sel == 2'b11 && ch_at_last
		|=> ch_ff == 4'h0)
		else $error("depth scan did not wrap");
	AST_KEEP: assert property (frame_evt && in_normal && top == 4'h0
		|=> $stable(last_ch_ff) && $stable(range_ff) && $stable(gpo_ff) && in_normal)
		else $error("keep frame changed a setting");
	AST_ENTER: assert property (frame_evt && is_alarm_req
		|=> in_alarm && group_ff == $past(req_group))
		else $error("alarm programming not entered");
	AST_EXIT: assert property (frame_evt && in_alarm && thr_exit
		|=> in_normal)
		else $error("exit flag ignored");
	AST_STAY: assert property (frame_evt && in_alarm && !thr_exit
		|=> in_alarm)
		else $error("left programming without exit");
	AST_NO_RANGE: assert property (frame_evt && in_alarm
		|=> $stable(range_ff) && $stable(gpo_ff) && $stable(last_ch_ff))
		else $error("setting changed while programming");
	AST_HI_WRITE: assert property (thr_write && thr_is_hi
		|=> thr_hi_ff[$past(thr_idx)] == $past(thr_val))
		else $error("high threshold not written");
	AST_ALARM_HI: assert property (ch_ok && res_top > thr_hi_ff[cmp_idx]
		|=> alarm_high)
		else $error("high alarm missed");
	AST_LO_WRITE: assert property (thr_write && !thr_is_hi
		|=> thr_lo_ff[$past(thr_idx)] == $past(thr_val))
		else $error("low threshold not written");
	AST_ALARM_LO: assert property (ch_ok && res_top < thr_lo_ff[cmp_idx]
		|=> alarm_low)
		else $error("low alarm missed");
	AST_GROUP_HOLD: assert property (frame_evt && in_alarm
		|=> $stable(group_ff))
		else $error("group changed while programming");
	AST_MANUAL_CH: assert property (frame_evt && mode_sel == 2'h0
		|=> ch_ff == $past(manual_channel))
		else $error("manual channel not taken");
	AST_CH_HOLD: assert property (!frame_evt
		|=> $stable(ch_ff))
		else $error("channel moved without a frame");
endmodule // afpd_decoder

`default_nettype wire

/* tb/afpd_host_model.sv */
// Host serial master model that shifts frames into the decoder
`timescale 1ns/1ps
`default_nettype none
module afpd_host_model (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	logic [15:0] rd_word;
	// ==========================================
	// Idle state: deselected, clock parked low
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b1;
		rd_word = 16'h0000;
	end
	// Whole frame, msb first, sdo captured before each rise
	task automatic send(input logic [15:0] word);
		#37;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdi = word[i];
			#80;
			rd_word[i] = sdo;
			sclk = 1'b1;
			#80;
			sclk = 1'b0;
		end
		#40;
		cs_n = 1'b1;
		sdi = ~sdi; // Line inverted after deselect, no stale value
		#200;
	endtask
endmodule // afpd_host_model
`default_nettype wire

/* tb/adc_frame_program_decoder_tb.sv */
// Self-checking bench of the frame program decoder
`timescale 1ns/1ps
`default_nettype none
module adc_frame_program_decoder_tb;
	logic clk, rst, sclk, cs_n, sdi, sdo, range_sel, prog_active, alarm_high, alarm_low;
	logic [1:0] mode_sel;
	logic [3:0] manual_channel, channel, last_channel_code, gpo_data;
	logic [11:0] conv_result;
	int bad_count = 0;
	int n_checks = 0;
	// ==========================================
	// Instances
	afpd_decoder #(.CHANNELS(16)) dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo), .mode_sel(mode_sel), .manual_channel(manual_channel),
		.conv_result(conv_result), .channel(channel), .last_channel_code(last_channel_code),
		.range_sel(range_sel), .gpo_data(gpo_data), .prog_active(prog_active),
		.alarm_high(alarm_high), .alarm_low(alarm_low));
	afpd_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	// Core clock
	always #10 clk = ~clk;
	// ==========================================
	// Shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic drive(input logic [1:0] m, input logic [3:0] mc, input logic [11:0] cr);
		@(posedge clk);
		#2;
		mode_sel = m;
		manual_channel = mc;
		conv_result = cr;
		repeat (3) @(posedge clk);
		#2;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk(last_channel_code, 16'h000F);
		chk({range_sel, gpo_data, prog_active, channel}, 16'h0000);
	endtask
	task automatic t_depth();
		logic [3:0] prev;
		drive(2'h0, 4'h0, 12'h000);
		host.send({4'h9, 2'h3, 4'h2, 6'h3F});
		chk(last_channel_code, 16'h0002);
		drive(2'h3, 4'h0, 12'h000);
		host.send(16'h0000);
		prev = 4'h1;
		chk(channel, 16'h0001);
		for (int i = 0; i < 6; i++)
		begin
			host.send({4'h0, 12'hFFF * i[0]});
			prev = (prev == 4'h2) ? 4'h0 : prev + 4'h1;
			chk(channel, {12'h000, prev});
			chk({range_sel, gpo_data, last_channel_code}, 16'h0002);
		end
	endtask
	task automatic t_manual_sdo();
		drive(2'h0, 4'h5, 12'hABC);
		host.send(16'h0000);
		host.send(16'h0000);
		chk(channel, 16'h0005);
		chk(host.rd_word, 16'h5ABC);
	endtask
	task automatic t_groups();
		for (int g = 0; g < 4; g++)
		begin
			host.send({2'h3, g[1:0], 12'h000});
			chk(prog_active, 16'h0001);
			host.send({2'h1, 2'h3, 2'h0, 10'h200});
			chk(prog_active, 16'h0000);
			drive(2'h0, {g[1:0], 2'h1}, 12'hFFC);
			host.send(16'h0000);
			chk({alarm_high, alarm_low}, 16'h0002);
			drive(2'h0, {g[1:0], 2'h1}, 12'h800);
			chk({alarm_high, alarm_low}, 16'h0000);
		end
	endtask
	task automatic t_full();
		host.send(16'hC000);
		host.send(16'h284F);
		chk({range_sel, gpo_data, prog_active}, 16'h0001);
		repeat (6) host.send({2'h2, 4'h0, 10'h100});
		chk(prog_active, 16'h0001);
		host.send({2'h2, 4'h4, 10'h100});
		chk(prog_active, 16'h0000);
		host.send({4'h9, 2'h0, 4'h5, 6'h00});
		chk(last_channel_code, 16'h0005);
		drive(2'h0, 4'h2, 12'h3FF);
		host.send(16'h0000);
		chk({alarm_high, alarm_low}, 16'h0001);
		// High threshold of channel 0 written as 04F in the first data frame
		drive(2'h0, 4'h0, 12'h200);
		host.send(16'h0000);
		chk({alarm_high, alarm_low}, 16'h0002);
	endtask
	task automatic t_mode();
		host.send(16'h1845);
		chk({range_sel, gpo_data}, 16'h0015);
		host.send(16'h0FFF);
		chk({range_sel, gpo_data, last_channel_code}, 16'h0155);
		host.send(16'hC000);
		host.send(16'h1840);
		chk({range_sel, gpo_data, prog_active}, 16'h002A);
		host.send(16'h2003);
		chk({range_sel, gpo_data}, 16'h0013);
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		mode_sel = 2'h0;
		manual_channel = 4'h0;
		conv_result = 12'h000;
		repeat (8) @(posedge clk);
		#2;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#2;
		t_reset();
		t_depth();
		t_manual_sdo();
		t_groups();
		t_full();
		t_mode();
		complete_run();
	end
	// Watchdog against a hung run
	initial
	begin
		#1000000;
		bad_count++;
		complete_run();
	end
endmodule // adc_frame_program_decoder_tb
`default_nettype wire
